// *** pfg_host.sv ***
// Host model that reads and clears interrupts over the register port
module pfg_host
    import pfg_pkg::*;
(
    input  wire logic  clk,
    input  wire byte_t reg_rdata,
    output logic [4:0] reg_addr,
    output logic       reg_wr,
    output logic       reg_rd,
    output byte_t      reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // ==========================================
    // Register cycles
    task automatic wr(input logic [4:0] a, input byte_t d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [4:0] a, output byte_t d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule

// *** pfg_pkg.sv ***
// Types shared by the power-up gate and interrupt aggregator
package pfg_pkg;

    // ==========================================
    // Power-up release states
    typedef enum logic [4:0] {
        ST_WAIT  = 5'b00001,
        ST_CHECK = 5'b00010,
        ST_HOLD  = 5'b00100,
        ST_REL   = 5'b01000,
        ST_ABORT = 5'b10000
    } pu_state_t;

    typedef logic [7:0] byte_t;

endpackage

// *** pfg_regs.svh ***
// Register indexes, field layout, reset values and timing counts
`ifndef PFG_REGS_SVH
`define PFG_REGS_SVH

// ==========================================
// Register indexes
`define IDX_SUMMARY  5'h00
`define IDX_GRP_BASE 5'h01
`define IDX_EN_LIVE  5'h16
`define IDX_STRIDE   5'h03

// ==========================================
// Field layout
`define SUM_EWARN_BIT 7
`define VALID_SYS    8'hfb
`define VALID_FULL   8'hff
`define VALID_SW     8'h0f
`define VALID_PWRON  8'hff
`define LIVE_SYS     8'h03
`define LIVE_PWRON   8'h81
`define MASK_RESET   8'h00

// ==========================================
// Timing
`define CLK_PERIOD_NS 10
`define HOLD_TIME_NS  2000000
`define EWARN_T0_NS   100000
`define EWARN_T1_NS   5000000
`define EWARN_T2_NS   20000000
`define EWARN_T3_NS   50000000
`define HOLD_CYCLES   (`HOLD_TIME_NS / `CLK_PERIOD_NS)
`define EWARN_C0      (`EWARN_T0_NS / `CLK_PERIOD_NS)
`define EWARN_C1      (`EWARN_T1_NS / `CLK_PERIOD_NS)
`define EWARN_C2      (`EWARN_T2_NS / `CLK_PERIOD_NS)
`define EWARN_C3      (`EWARN_T3_NS / `CLK_PERIOD_NS)

`endif

// *** powerup_fault_gate_and_irq.sv ***
// Power-up reset gating on power-good and two-level interrupt aggregation
`include "pfg_regs.svh"

module powerup_fault_gate_and_irq
    import pfg_pkg::*;
#(
    parameter int unsigned NREG        = 4,
    parameter int unsigned HOLD_CYCLES = `HOLD_CYCLES,
    parameter int unsigned EWARN_C0    = `EWARN_C0,
    parameter int unsigned EWARN_C1    = `EWARN_C1,
    parameter int unsigned EWARN_C2    = `EWARN_C2,
    parameter int unsigned EWARN_C3    = `EWARN_C3
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              power_good_gate_option,
    input  wire logic [1:0]        shutdown_warning_lead_time,
    input  wire logic [NREG-1:0]   regulator_in_regulation,
    input  wire logic              seq_at_release,
    input  wire logic [NREG-1:0]   slot_enabled,
    input  wire logic [NREG-1:0]   blank_done,
    input  wire logic              shutdown_request,
    input  wire byte_t             grp_event [7],
    input  wire byte_t             grp_live [7],
    input  wire logic [NREG-1:0]   en_pin_level,
    input  wire logic [4:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire byte_t             reg_wdata,
    output byte_t                  reg_rdata,
    output logic                   host_reset_out_n,
    output logic                   seq_pause,
    output logic                   regulators_off,
    output logic [NREG-1:0]        monitor_en,
    output logic [NREG-1:0]        fault_start,
    output logic                   power_good_pin_gpio_ok,
    output logic                   shutdown_go,
    output logic                   irq_out_n_o,
    output logic                   irq_out_n_oe
);

    // ==========================================
    // Parameter checks
    if (NREG < 1 || NREG > 4) begin : g_chk_nreg
        $error("NREG must be 1 to 4");
    end
    if (HOLD_CYCLES < 1 || EWARN_C0 < 1) begin : g_chk_cnt
        $error("Counts must be at least one");
    end

    // ==========================================
    // Power-good synchroniser
    logic [NREG-1:0] pg_m_q;
    logic [NREG-1:0] pg_s_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pg_m_q <= '0;
            pg_s_q <= '0;
        end else begin
            pg_m_q <= regulator_in_regulation;
            pg_s_q <= pg_m_q;
        end
    end

    // ==========================================
    // Power-up release machine
    pu_state_t   st_q;
    pu_state_t   st_d;
    logic [31:0] hold_q;
    logic        rel_q;
    logic        off_q;
    logic        gpio_q;

    wire all_good  = &(pg_s_q | ~slot_enabled);
    wire hold_end  = hold_q == 32'(HOLD_CYCLES - 1);
    wire in_check  = st_q == ST_CHECK;
    wire in_hold   = st_q == ST_HOLD;
    wire any_on    = |slot_enabled;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_WAIT: begin
                if (seq_at_release && !power_good_gate_option) begin
                    st_d = ST_REL;
                end else if (seq_at_release) begin
                    st_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                st_d = all_good ? ST_REL : ST_HOLD;
            end
            ST_HOLD: begin
                if (all_good) begin
                    st_d = ST_REL;
                end else if (hold_end) begin
                    st_d = ST_ABORT;
                end
            end
            ST_REL:   st_d = ST_REL;
            ST_ABORT: st_d = ST_ABORT;
            default:  st_d = ST_WAIT;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q   <= ST_WAIT;
            hold_q <= '0;
            rel_q  <= 1'b0;
            off_q  <= 1'b0;
            gpio_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            hold_q <= in_hold ? hold_q + 32'd1 : '0;
            rel_q  <= st_d == ST_REL;
            off_q  <= st_d == ST_ABORT;
            gpio_q <= gpio_q | any_on;
        end
    end

    assign host_reset_out_n = rel_q;
    assign regulators_off   = off_q;
    // Only the release check and hold pause; later faults never do
    assign seq_pause        = in_check | in_hold;
    assign power_good_pin_gpio_ok    = !power_good_gate_option | gpio_q;

    // OV/UV blanked until release, then per regulator
    assign monitor_en = {NREG{rel_q}} & slot_enabled & blank_done;

    // Faults of enabled supplies start protection
    assign fault_start = monitor_en & (grp_live[3][NREG-1:0]
                       | grp_live[4][NREG-1:0]
                       | grp_live[5][NREG-1:0]);

    // Power-good shortfall at the check reported as undervoltage
    wire [NREG-1:0] pg_fail = in_check ? slot_enabled & ~pg_s_q : '0;

    // ==========================================
    // Early warning of shutdown
    logic [31:0] ew_q;
    logic        ew_run_q;
    logic        ewarn_q;
    logic        go_q;
    logic [31:0] ew_lead;

    always_comb begin
        case (shutdown_warning_lead_time)
            2'b00:   ew_lead = 32'(EWARN_C0);
            2'b01:   ew_lead = 32'(EWARN_C1);
            2'b10:   ew_lead = 32'(EWARN_C2);
            default: ew_lead = 32'(EWARN_C3);
        endcase
    end

    wire ew_start = shutdown_request && !ew_run_q && !go_q;
    wire ew_done  = ew_run_q && ew_q == ew_lead - 32'd1;
    wire sum_hit  = reg_wr && reg_addr == `IDX_SUMMARY;
    wire ew_clr   = sum_hit && reg_wdata[`SUM_EWARN_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ew_q     <= '0;
            ew_run_q <= 1'b0;
            ewarn_q  <= 1'b0;
            go_q     <= 1'b0;
        end else begin
            ew_q     <= ew_run_q ? ew_q + 32'd1 : '0;
            ew_run_q <= ew_start | (ew_run_q & !ew_done);
            ewarn_q  <= ew_start | (ewarn_q & !ew_clr);
            go_q     <= go_q | ew_done;
        end
    end

    assign shutdown_go = go_q;

    // ==========================================
    // Second-level latches and masks
    localparam byte_t VALID [7] = '{`VALID_SYS, `VALID_FULL,
        `VALID_SW, `VALID_SW, `VALID_SW, `VALID_SW, `VALID_PWRON};
    localparam byte_t LIVEV [7] = '{`LIVE_SYS, `VALID_FULL,
        8'h00, `VALID_SW, `VALID_SW, `VALID_SW, `LIVE_PWRON};

    byte_t      latch_q [7];
    byte_t      mask_q  [7];
    byte_t      rd_grp  [7];
    logic [6:0] pending;
    logic [6:0] rd_sel;

    for (genvar g = 0; g < 7; g++) begin : g_grp
        wire [4:0] base  = 5'(`IDX_GRP_BASE + `IDX_STRIDE * g);
        wire       l_hit = reg_addr == base;
        wire       m_hit = reg_addr == 5'(base + 5'd1);
        wire       s_hit = reg_addr == 5'(base + 5'd2);
        wire byte_t clr  = (reg_wr && l_hit) ? reg_wdata : 8'h00;
        wire byte_t ext  = (g == 4) ? 8'(pg_fail) : 8'h00;
        // Raw events set latches whether or not protection is bypassed
        wire byte_t set  = (grp_event[g] | ext) & VALID[g];

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                latch_q[g] <= 8'h00;
                mask_q[g]  <= `MASK_RESET;
            end else begin
                latch_q[g] <= (latch_q[g] & ~clr) | set;
                if (reg_wr && m_hit) begin
                    mask_q[g] <= reg_wdata & VALID[g];
                end
            end
        end

        assign pending[g] = |(latch_q[g] & ~mask_q[g]);
        assign rd_sel[g]  = l_hit | m_hit | s_hit;
        assign rd_grp[g]  = l_hit ? latch_q[g]
                          : m_hit ? mask_q[g]
                          : s_hit ? grp_live[g] & LIVEV[g]
                          : 8'h00;
    end

    // ==========================================
    // Summary register and pin
    wire byte_t summary = {ewarn_q, pending};

    logic irq_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |summary;
        end
    end

    assign irq_out_n_o  = 1'b0;
    assign irq_out_n_oe = irq_q;

    // ==========================================
    // Register read path
    byte_t rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < 7; i++) begin
            if (rd_sel[i]) begin
                rd_mux = rd_grp[i];
            end
        end
        if (reg_addr == `IDX_SUMMARY) begin
            rd_mux = summary;
        end else if (reg_addr == `IDX_EN_LIVE) begin
            rd_mux = 8'(en_pin_level);
        end
    end

    byte_t rdata_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    gate_off_rel_a: assert property (
        st_q == ST_WAIT && seq_at_release
        && !power_good_gate_option |=> host_reset_out_n)
        else $error("reset not released with gate off");

    gate_on_pg_a: assert property (
        $rose(host_reset_out_n) && power_good_gate_option
        |-> $past(all_good))
        else $error("reset released without power good");

    uvov_blank_a: assert property (
        !host_reset_out_n |-> monitor_en == '0)
        else $error("monitor active before release");

    hold_pause_a: assert property (
        in_hold && !all_good |-> seq_pause && !host_reset_out_n)
        else $error("hold without pause");

    abort_timer_a: assert property (
        in_hold && hold_end && !all_good
        |=> st_q == ST_ABORT ##1 regulators_off)
        else $error("abort not taken at hold end");

    no_pause_after_a: assert property (
        host_reset_out_n |-> !seq_pause)
        else $error("pause after release");

    set_wins_a: assert property (
        grp_event[1] != 8'h00
        |=> (latch_q[1] & $past(grp_event[1])) == $past(grp_event[1]))
        else $error("event lost on clear");

    pin_follow_a: assert property (
        (|summary) |=> irq_out_n_oe ##0 !irq_out_n_o)
        else $error("pin not asserted");

    pin_release_a: assert property (
        !(|summary) |=> !irq_out_n_oe)
        else $error("pin held with nothing pending");

    auto_clear_a: assert property (
        reg_wr && reg_addr == `IDX_GRP_BASE
        && reg_wdata == 8'hff && grp_event[0] == 8'h00
        |=> !summary[0])
        else $error("summary bit stuck");

    live_read_a: assert property (
        reg_rd && reg_addr == `IDX_EN_LIVE
        |=> reg_rdata == 8'($past(en_pin_level)))
        else $error("live read wrong");

    ewarn_lead_a: assert property (
        $rose(shutdown_go) |-> ewarn_q || $past(ew_clr))
        else $error("shutdown without warning");

endmodule

// *** tb_powerup_fault_gate_and_irq.sv ***
// Self-checking bench for power-up gating and interrupt aggregation
module tb_powerup_fault_gate_and_irq;
    import pfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic gate = 1'b0;
    logic [1:0] lead = 2'b00;
    logic [3:0] pg = 4'h0;
    logic [3:0] slot = 4'h0;
    logic [3:0] blank = 4'h0;
    logic [3:0] enp = 4'ha;
    logic sar = 1'b0;
    logic sreq = 1'b0;
    byte_t ev [7] = '{default: 8'h00};
    byte_t live [7] = '{default: 8'h00};
    logic [4:0] addr;
    logic wr, rd, hro_n, pause, roff, gpio_ok, sgo, irq_o, irq_oe;
    byte_t wdata, rdata, v;
    logic [3:0] mon, fst;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    powerup_fault_gate_and_irq #(.NREG(4), .HOLD_CYCLES(20), .EWARN_C0(4), .EWARN_C1(6), .EWARN_C2(8),
        .EWARN_C3(10)) powerup_fault_gate_and_irq_i (
        .clk(clk), .rst(rst), .power_good_gate_option(gate), .shutdown_warning_lead_time(lead),
        .regulator_in_regulation(pg), .seq_at_release(sar), .slot_enabled(slot), .blank_done(blank),
        .shutdown_request(sreq), .grp_event(ev), .grp_live(live), .en_pin_level(enp),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
        .host_reset_out_n(hro_n), .seq_pause(pause), .regulators_off(roff), .monitor_en(mon),
        .fault_start(fst), .power_good_pin_gpio_ok(gpio_ok), .shutdown_go(sgo), .irq_out_n_o(irq_o),
        .irq_out_n_oe(irq_oe));

    pfg_host pfg_host_i (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata));

    // ==========================================
    // Helpers
    task automatic chk(input byte_t got, input byte_t exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input logic g, input logic [1:0] l);
        rst = 1'b1;
        gate = g;
        lead = l;
        sar = 1'b0;
        tick(2);
        rst = 1'b0;
    endtask

    task automatic pulse(input int g, input byte_t b);
        tick(1);
        ev[g] = b;
        tick(1);
        ev[g] = 8'h00;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_gate_off;
        do_reset(1'b0, 2'b00);
        slot = 4'h3;
        blank = 4'h1;
        tick(1);
        sar = 1'b1;
        chk(mon, 4'h0);
        tick(2);
        chk(hro_n, 1'b1);
        chk(mon, 4'h1);
        chk(gpio_ok, 1'b1);
    endtask

    task automatic t_irq;
        slot = 4'hf;
        blank = 4'hf;
        live[4] = 8'h05;
        tick(1);
        chk(fst, 4'h5);
        pfg_host_i.rd(5'h0f, v);
        chk(v, 8'h05);
        enp = 4'h5;
        pfg_host_i.rd(5'h16, v);
        chk(v, 8'h05);
        pulse(4, 8'h02);
        tick(1);
        chk({irq_oe, irq_o}, 2'b10);
        pfg_host_i.rd(5'h0d, v);
        chk(v, 8'h02);
        pfg_host_i.rd(5'h00, v);
        chk(v, 8'h10);
        pfg_host_i.wr(5'h0e, 8'h02);
        tick(1);
        chk(irq_oe, 1'b0);
        pfg_host_i.rd(5'h00, v);
        chk(v, 8'h00);
        pfg_host_i.wr(5'h0e, 8'h00);
        pulse(0, 8'h01);
        tick(1);
        chk(irq_oe, 1'b1);
        pfg_host_i.wr(5'h0d, 8'h02);
        tick(1);
        chk(irq_oe, 1'b1);
        pfg_host_i.rd(5'h00, v);
        chk(v, 8'h01);
        pfg_host_i.wr(5'h01, 8'hff);
        tick(1);
        chk(irq_oe, 1'b0);
        fork
            pfg_host_i.wr(5'h0d, 8'h02);
            pulse(4, 8'h02);
        join
        pfg_host_i.rd(5'h0d, v);
        chk(v, 8'h02);
        pfg_host_i.wr(5'h0d, 8'h02);
    endtask

    task automatic t_gate_good;
        pg = 4'h3;
        slot = 4'h0;
        do_reset(1'b1, 2'b00);
        chk(gpio_ok, 1'b0);
        slot = 4'h3;
        tick(1);
        sar = 1'b1;
        tick(1);
        chk(hro_n, 1'b0);
        tick(1);
        chk(hro_n, 1'b1);
        chk({pause, gpio_ok}, 2'b01);
    endtask

    task automatic t_hold(input logic fix);
        pg = 4'h7;
        slot = 4'hf;
        do_reset(1'b1, 2'b00);
        tick(1);
        sar = 1'b1;
        tick(3);
        chk({pause, hro_n}, 2'b10);
        pfg_host_i.rd(5'h0d, v);
        chk(v, 8'h08);
        if (fix) begin
            pg = 4'hf;
            tick(4);
            chk({pause, hro_n, roff}, 3'b010);
        end else begin
            tick(15);
            chk({hro_n, roff}, 2'b00);
            tick(1);
            chk({hro_n, roff}, 2'b01);
        end
    endtask

    task automatic t_ewarn;
        int n [4] = '{4, 6, 8, 10};
        for (int l = 0; l < 4; l++) begin
            do_reset(1'b0, 2'(l));
            tick(1);
            sreq = 1'b1;
            tick(1);
            sreq = 1'b0;
            tick(n[l] - 1);
            chk(sgo, 1'b0);
            tick(1);
            chk(sgo, 1'b1);
            pfg_host_i.rd(5'h00, v);
            chk(v, 8'h80);
        end
        pfg_host_i.wr(5'h00, 8'h80);
        pfg_host_i.rd(5'h00, v);
        chk(v, 8'h00);
    endtask

    // ==========================================
    // Run control
    task automatic summarize;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        tick(12);
        rst = 1'b0;
        t_gate_off();
        t_irq();
        t_gate_good();
        t_hold(1'b1);
        t_hold(1'b0);
        t_ewarn();
        summarize();
    end
endmodule
